// >>> rtl/usctl_defs.vh
/*
  constants for the two-port serial control register block: special-function
  addresses, field positions, reset value and mode encodings.
  assumes it is included by bare name from the design files.
*/
`ifndef USCTL_DEFS_VH
`define USCTL_DEFS_VH

// ============================================================
// addresses and reset
`define USCTL_ADDR_PORT0  8'h98
`define USCTL_ADDR_PORT1  8'hd8
`define USCTL_RESET_VAL   8'h00

// ============================================================
// field positions
`define USCTL_BIT_MODE_HI 7
`define USCTL_BIT_MODE_LO 6
`define USCTL_BIT_MP_EN   5
`define USCTL_BIT_RX_EN   4
`define USCTL_BIT_TX9     3
`define USCTL_BIT_RX9     2
`define USCTL_BIT_TX_DONE 1
`define USCTL_BIT_RX_DONE 0

// ============================================================
// mode encodings
`define USCTL_MODE0       2'b00
`define USCTL_MODE1       2'b01
`define USCTL_MODE2       2'b10
`define USCTL_MODE3       2'b11

`endif

// >>> rtl/usctl_port.v
/*
  one serial port control register with its hardware flag logic.
  assumes shifter events are one-cycle pulses synchronous to i_clk and that
  the special-function write strobe is already decoded to this port.
*/
`timescale 1ns/1ns
`include "usctl_defs.vh"

module usctl_port (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_reset,
  // register access
  input  wire       i_wr,
  input  wire [7:0] i_wdata,
  // shifter events
  input  wire       i_tx_done,
  input  wire       i_rx_done,
  input  wire       i_rx_ninth,
  // state
  output wire [7:0] o_value,
  output wire [1:0] o_mode,
  output wire       o_rx_start_ok,
  output wire       o_tx_ninth_used,
  output wire       o_tx_ninth,
  output wire       o_irq
);

  reg  [7:0] ctrl_r;
  reg  [7:0] ctrl_nxt;
  wire [1:0] mode;
  wire       mp_en;
  wire       rx_accept;

  assign mode  = {ctrl_r[`USCTL_BIT_MODE_HI], ctrl_r[`USCTL_BIT_MODE_LO]};
  assign mp_en = ctrl_r[`USCTL_BIT_MP_EN];

  // multiprocessor gate; mode 0 ignores the enable bit
  assign rx_accept = (mode == `USCTL_MODE0) | ~mp_en | i_rx_ninth;

  // receive start condition, mode 0 also needs flag clear
  assign o_rx_start_ok = ctrl_r[`USCTL_BIT_RX_EN] &
                         ((mode != `USCTL_MODE0) | ~ctrl_r[`USCTL_BIT_RX_DONE]);

  // ninth transmit bit only used in modes 2 and 3
  assign o_tx_ninth_used = mode[1];
  assign o_tx_ninth      = ctrl_r[`USCTL_BIT_TX9];

  assign o_irq   = ctrl_r[`USCTL_BIT_TX_DONE] | ctrl_r[`USCTL_BIT_RX_DONE];
  assign o_value = ctrl_r;
  assign o_mode  = mode;

  // next value: software write first, hardware sets win over clears
  always @* begin
    ctrl_nxt = ctrl_r;
    if (i_wr) begin
      ctrl_nxt = i_wdata;
    end
    // transmit flag set on shifter completion
    if (i_tx_done) begin
      ctrl_nxt[`USCTL_BIT_TX_DONE] = 1'b1;
    end
    // store ninth bit outside mode 0 and flag an accepted frame
    if (i_rx_done && rx_accept) begin
      ctrl_nxt[`USCTL_BIT_RX_DONE] = 1'b1;
      if (mode != `USCTL_MODE0) begin
        ctrl_nxt[`USCTL_BIT_RX9] = i_rx_ninth;
      end
    end
  end

  // only a write can clear flags; reset value
  always @(posedge i_clk) begin
    if (i_reset) begin
      ctrl_r <= `USCTL_RESET_VAL;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

endmodule

// >>> rtl/usctl_top.v
/*
  serial control registers for two identical ports on the special-function bus.
  assumes one-cycle write and read strobes with an 8-bit address, and shifter
  event pulses from the bit engines outside; read data is registered.
*/
`timescale 1ns/1ns
`include "usctl_defs.vh"

module usctl_top (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_reset,
  // special-function bus
  input  wire [7:0] i_sfr_addr,
  input  wire       i_sfr_wr,
  input  wire       i_sfr_rd,
  input  wire [7:0] i_sfr_wdata,
  output reg  [7:0] o_sfr_rdata,
  output reg        o_sfr_hit,
  // port 0 shifter events
  input  wire       i_tx0_done,
  input  wire       i_rx0_done,
  input  wire       i_rx0_ninth,
  // port 1 shifter events
  input  wire       i_tx1_done,
  input  wire       i_rx1_done,
  input  wire       i_rx1_ninth,
  // port 0 control toward shifters
  output reg  [1:0] o_mode0,
  output reg        o_rx0_start_ok,
  output reg        o_tx0_ninth_used,
  output reg        o_tx0_ninth,
  // port 1 control toward shifters
  output reg  [1:0] o_mode1,
  output reg        o_rx1_start_ok,
  output reg        o_tx1_ninth_used,
  output reg        o_tx1_ninth,
  // shared interrupt request
  output reg        o_irq
);

  wire       sel0;
  wire       sel1;
  wire [7:0] val0;
  wire [7:0] val1;
  wire [1:0] mode0;
  wire [1:0] mode1;
  wire       rx_ok0;
  wire       rx_ok1;
  wire       tx9u0;
  wire       tx9u1;
  wire       tx90;
  wire       tx91;
  wire       irq0;
  wire       irq1;

  // ============================================================
  // address decode
  // fixed special-function addresses
  assign sel0 = (i_sfr_addr == `USCTL_ADDR_PORT0);
  assign sel1 = (i_sfr_addr == `USCTL_ADDR_PORT1);

  // ============================================================
  // port instances
  usctl_port u_port0 (
    .i_clk           (i_clk),
    .i_reset         (i_reset),
    .i_wr            (i_sfr_wr & sel0),
    .i_wdata         (i_sfr_wdata),
    .i_tx_done       (i_tx0_done),
    .i_rx_done       (i_rx0_done),
    .i_rx_ninth      (i_rx0_ninth),
    .o_value         (val0),
    .o_mode          (mode0),
    .o_rx_start_ok   (rx_ok0),
    .o_tx_ninth_used (tx9u0),
    .o_tx_ninth      (tx90),
    .o_irq           (irq0)
  );

  usctl_port u_port1 (
    .i_clk           (i_clk),
    .i_reset         (i_reset),
    .i_wr            (i_sfr_wr & sel1),
    .i_wdata         (i_sfr_wdata),
    .i_tx_done       (i_tx1_done),
    .i_rx_done       (i_rx1_done),
    .i_rx_ninth      (i_rx1_ninth),
    .o_value         (val1),
    .o_mode          (mode1),
    .o_rx_start_ok   (rx_ok1),
    .o_tx_ninth_used (tx9u1),
    .o_tx_ninth      (tx91),
    .o_irq           (irq1)
  );

  // ============================================================
  // registered outputs; one cycle behind the control registers
  always @(posedge i_clk) begin
    if (i_reset) begin
      o_sfr_rdata      <= 8'h00;
      o_sfr_hit        <= 1'b0;
      o_mode0          <= 2'h0;
      o_rx0_start_ok   <= 1'b0;
      o_tx0_ninth_used <= 1'b0;
      o_tx0_ninth      <= 1'b0;
      o_mode1          <= 2'h0;
      o_rx1_start_ok   <= 1'b0;
      o_tx1_ninth_used <= 1'b0;
      o_tx1_ninth      <= 1'b0;
      o_irq            <= 1'b0;
    end else begin
      // unmapped reads return zero with no hit
      o_sfr_hit <= i_sfr_rd & (sel0 | sel1);
      if (i_sfr_rd && sel0) begin
        o_sfr_rdata <= val0;
      end else if (i_sfr_rd && sel1) begin
        o_sfr_rdata <= val1;
      end else begin
        o_sfr_rdata <= 8'h00;
      end
      o_mode0          <= mode0;
      o_rx0_start_ok   <= rx_ok0;
      o_tx0_ninth_used <= tx9u0;
      o_tx0_ninth      <= tx90;
      o_mode1          <= mode1;
      o_rx1_start_ok   <= rx_ok1;
      o_tx1_ninth_used <= tx9u1;
      o_tx1_ninth      <= tx91;
      o_irq            <= irq0 | irq1;
    end
  end

endmodule

// >>> verification/usctl_props.sv
/* checker for usctl_top; sees only its ports, bound below the module */
`timescale 1ns/1ns
module usctl_props (
  input wire logic       i_clk, i_reset, i_sfr_wr, i_sfr_rd, o_sfr_hit, i_tx0_done, o_irq,
  input wire logic       o_tx0_ninth_used, o_tx1_ninth_used,
  input wire logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata,
  input wire logic [1:0] o_mode0, o_mode1
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ====================
  // assertions
  a_mode_port0: assert property (
    i_sfr_wr && i_sfr_addr == 8'h98 |=> ##1 {o_mode0, 6'h00} == ($past(i_sfr_wdata, 2) & 8'hc0)
  ) else $error("port 0 mode wrong");
  a_mode_port1: assert property (
    i_sfr_wr && i_sfr_addr == 8'hd8 |=> ##1 {o_mode1, 6'h00} == ($past(i_sfr_wdata, 2) & 8'hc0)
  ) else $error("port 1 mode wrong");
  a_ninth_use0: assert property (o_tx0_ninth_used == o_mode0[1])
    else $error("port 0 ninth use wrong");
  a_ninth_use1: assert property (o_tx1_ninth_used == o_mode1[1])
    else $error("port 1 ninth use wrong");
  a_read_hit: assert property (
    i_sfr_rd && (i_sfr_addr == 8'h98 || i_sfr_addr == 8'hd8) |=> o_sfr_hit
  ) else $error("mapped read missed");
  a_read_unmapped: assert property (
    i_sfr_rd && i_sfr_addr != 8'h98 && i_sfr_addr != 8'hd8 |=> o_sfr_rdata == 8'h00 && !o_sfr_hit
  ) else $error("unmapped read answered");
  a_read_idle: assert property (!i_sfr_rd |=> o_sfr_rdata == 8'h00 && !o_sfr_hit)
    else $error("read data without read");
  a_tx_irq: assert property (i_tx0_done |=> ##1 o_irq)
    else $error("transmit flag gave no request");
  a_flag_kept: assert property ($fell(o_irq) |-> $past(i_sfr_wr, 2))
    else $error("request dropped without a write");
endmodule
bind usctl_top usctl_props u_props (.*);

// >>> verification/usctl_remote.sv
/* far serial device: answers a request with one shifter event after a chosen wait */
`timescale 1ns/1ns
module usctl_remote (
  input wire logic       i_clk, i_tx_req, i_rx_req, i_bit,
  input wire logic [3:0] i_wait,
  output logic           o_tx_done = 0, o_rx_done = 0, o_ninth = 0
);
  integer cnt = -1;
  logic   rx = 0, b = 0;
  // ====================
  // ninth line toggles off the pulse so a stale level never passes
  always @(posedge i_clk) begin
    o_tx_done <= cnt == 0 && !rx;
    o_rx_done <= cnt == 0 && rx;
    o_ninth <= cnt == 0 ? b : ~o_ninth;
    if (cnt >= 0) cnt <= cnt - 1;
    if (i_tx_req || i_rx_req) begin
      cnt <= i_wait;
      rx <= i_rx_req;
      b <= i_bit;
    end
  end
endmodule

// >>> verification/test_uart_serial_port_control.sv
/* self-checking bench for usctl_top; a reference model mirrors both registers */
`timescale 1ns/1ns
module test_uart_serial_port_control;
  logic        i_clk = 0, i_reset = 1, wr = 0, rd = 0, bitv = 0, hit;
  logic [7:0]  addr = 0, wd = 0, v, a, rdat, r [2];
  logic [1:0]  txq = 0, rxq = 0, txd, rxd, nin;
  logic [3:0]  wt = 0;
  logic [10:0] seen;
  integer      seed = 37, err_total = 0, checks = 0, i, op, p;
  // ====================
  // clock, far side and device
  initial forever #5 i_clk = ~i_clk;
  usctl_remote u_far0 (.i_clk(i_clk), .i_tx_req(txq[0]), .i_rx_req(rxq[0]), .i_bit(bitv),
    .i_wait(wt), .o_tx_done(txd[0]), .o_rx_done(rxd[0]), .o_ninth(nin[0]));
  usctl_remote u_far1 (.i_clk(i_clk), .i_tx_req(txq[1]), .i_rx_req(rxq[1]), .i_bit(bitv),
    .i_wait(wt), .o_tx_done(txd[1]), .o_rx_done(rxd[1]), .o_ninth(nin[1]));
  usctl_top u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_sfr_addr(addr), .i_sfr_wr(wr),
    .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdat), .o_sfr_hit(hit),
    .i_tx0_done(txd[0]), .i_rx0_done(rxd[0]), .i_rx0_ninth(nin[0]), .i_tx1_done(txd[1]),
    .i_rx1_done(rxd[1]), .i_rx1_ninth(nin[1]), .o_mode0(seen[10:9]), .o_rx0_start_ok(seen[8]),
    .o_tx0_ninth_used(seen[7]), .o_tx0_ninth(seen[6]), .o_mode1(seen[5:4]),
    .o_rx1_start_ok(seen[3]), .o_tx1_ninth_used(seen[2]), .o_tx1_ninth(seen[1]),
    .o_irq(seen[0]));
  // reference registers; write first, then hardware sets
  always @(posedge i_clk)
    for (int k = 0; k < 2; k++) begin
      logic [7:0] m;
      m = r[k];
      if (wr && addr == (k ? 8'hd8 : 8'h98)) m = wd;
      if (txd[k]) m[1] = 1'b1;
      if (rxd[k] && r[k][7:6] == 2'b00) m[0] = 1'b1;
      else if (rxd[k] && !(r[k][5] && !nin[k])) m[2:0] = {nin[k], m[1], 1'b1};
      r[k] <= i_reset ? 8'h00 : m;
    end
  function logic [10:0] expo();
    expo[0] = |{r[0][1:0], r[1][1:0]};
    for (int k = 0; k < 2; k++)
      expo[10-5*k -: 5] = {r[k][7:6], r[k][4] & (r[k][7:6] != 0 | !r[k][0]), r[k][7], r[k][3]};
  endfunction
  task chk(input logic [10:0] s, input logic [10:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task rdreg(input logic [7:0] x);
    @(posedge i_clk) begin
      addr <= x;
      rd <= 1;
    end
    @(posedge i_clk) rd <= 0;
    @(negedge i_clk);
    chk(rdat, x == 8'h98 ? r[0] : x == 8'hd8 ? r[1] : 8'h00);
    chk(hit, x == 8'h98 || x == 8'hd8);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ====================
  // random register traffic and far-side events
  initial begin
    repeat (6) @(posedge i_clk);
    i_reset <= 0;
    rdreg(8'h98);
    rdreg(8'hd8);
    for (i = 0; i < 400; i++) begin
      op = {$random(seed)} % 4;
      p = {$random(seed)} % 2;
      a = (p ? 8'hd8 : 8'h98) | ({$random(seed)} % 4 == 0);
      v = $random(seed);
      if (v[7:6] == 2'b00) v[5] = 1'b0;
      if (op == 3) rdreg(a);
      else begin
        @(posedge i_clk);
        wr <= op == 0;
        addr <= a;
        wd <= v;
        txq[p] <= op == 1;
        rxq[p] <= op == 2;
        bitv <= $random(seed);
        wt <= $random(seed);
        @(posedge i_clk);
        wr <= 0;
        txq <= 0;
        rxq <= 0;
      end
      repeat (20) @(posedge i_clk);
      @(negedge i_clk);
      chk(seen, expo());
    end
    finish_test;
  end
  // hang guard: about twice the expected run
  initial begin
    #200000;
    err_total++;
    finish_test;
  end
endmodule
